/* File: rtl/fdc_regs_pkg.sv */
/*
 * Offsets, reset values, timing counts and carrier types for the disk
 * controller status and rate-select register block.
 * Assumes a 40 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package fdc_regs_pkg;
    localparam logic [7:0] MAIN_STATUS_OFS = 8'h00;
    localparam logic [7:0] RATE_SELECT_OFS = 8'h04;
    localparam logic [7:0] CONFIG_CONTROL_OFS = 8'h08;
    localparam logic [7:0] TAPE_ASSIGN_OFS = 8'h0C;
    localparam logic [7:0] CLOCK_OPTION_OFS = 8'h10;
    localparam logic [7:0] CORE_STATE_OFS = 8'h14;

    localparam logic [7:0] RATE_SELECT_RST = 8'h02;
    localparam logic [1:0] RATE_CODE_RST = 2'h2;
    localparam logic [1:0] CLOCK_OPTION_RST = 2'h1;
    localparam logic [1:0] TAPE_ASSIGN_RST = 2'h0;
    localparam logic [7:0] MSR_IDLE = 8'h00;
    localparam logic [7:0] MSR_READY = 8'h80;
    localparam int RS_SRST_BIT = 7;
    localparam int RS_LOWPWR_BIT = 6;
    localparam int CLKOPT_HS_BIT = 1;

    localparam logic [2:0] PRECOMP_ZERO = 3'h7;
    localparam logic [2:0] PRECOMP_DEFAULT = 3'h0;
    localparam logic [3:0] PRECOMP_DEF_2M = 4'h1;
    localparam logic [3:0] PRECOMP_DEF_1M = 4'h2;
    localparam logic [3:0] PRECOMP_DEF_LOW = 4'h6;

    localparam int CLK_MHZ = 40;
    localparam int STARTUP_NS = 2500;
    localparam int SRST_NS = 100;
    localparam logic [6:0] STARTUP_CYC = 7'(STARTUP_NS * CLK_MHZ / 1000);
    localparam logic [2:0] SRST_CYC = 3'((SRST_NS * CLK_MHZ + 999) / 1000);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        RATE_250K, RATE_300K, RATE_500K, RATE_1M, RATE_2M, RATE_ILLEGAL
    } rate_t;

    typedef struct packed {
        logic first_cmd;
        logic last_cmd;
        logic no_result;
        logic seek_cmd;
        logic [1:0] seek_unit;
        logic last_result;
        logic sense_first;
        logic [1:0] sense_unit;
        logic byte_done;
        logic next_ready;
        logic dir_read;
        logic nondma;
        logic irq;
        logic data_access;
        logic oc_reset;
        logic [7:0] cur_track;
        logic [7:0] pc_track;
    } engine_evt_t;

    typedef struct packed {
        logic ctrl_reset;
        logic low_power;
        rate_t rate;
        logic [1:0] rate_code;
        logic [3:0] precomp_units;
        logic precomp_active;
        logic [3:0] tape_mask;
    } ctl_out_t;
endpackage

/* File: rtl/fdc_status_rate.sv */
/*
 * Main status and data-rate select register block of a floppy disk
 * controller, reached over AXI4-Lite; command engine events arrive as
 * one-cycle pulses and levels in an engine_evt_t, controls leave in a
 * ctl_out_t. Assumes one write and one read outstanding at a time.
 */
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module fdc_status_rate (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Command engine side
    input wire fdc_regs_pkg::engine_evt_t evt,
    output fdc_regs_pkg::ctl_out_t ctl
);

    function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
        sel = (a[7:2] == ofs[7:2]);
    endfunction

    function automatic logic [3:0] onehot(input logic [1:0] u);
        onehot = 4'h1 << u;
    endfunction

    function automatic fdc_regs_pkg::rate_t rate_of(input logic [1:0] c,
                                                     input logic hs);
        if (hs) begin
            rate_of = (c == 2'h3) ? fdc_regs_pkg::RATE_2M : fdc_regs_pkg::RATE_ILLEGAL;
        end else begin
            case (c)
                2'h3: rate_of = fdc_regs_pkg::RATE_1M;
                2'h0: rate_of = fdc_regs_pkg::RATE_500K;
                2'h1: rate_of = fdc_regs_pkg::RATE_300K;
                default: rate_of = fdc_regs_pkg::RATE_250K;
            endcase
        end
    endfunction

    // Delay in 20.8 ns units; a 24 MHz step is two units
    function automatic logic [3:0] precomp_of(input logic [2:0] c,
                                              input fdc_regs_pkg::rate_t r,
                                              input logic hs);
        if (c == fdc_regs_pkg::PRECOMP_ZERO) begin
            precomp_of = 4'h0;
        end else if (c == fdc_regs_pkg::PRECOMP_DEFAULT) begin
            if (r == fdc_regs_pkg::RATE_2M) begin
                precomp_of = fdc_regs_pkg::PRECOMP_DEF_2M;
            end else if (r == fdc_regs_pkg::RATE_1M) begin
                precomp_of = fdc_regs_pkg::PRECOMP_DEF_1M;
            end else begin
                precomp_of = fdc_regs_pkg::PRECOMP_DEF_LOW;
            end
        end else begin
            precomp_of = hs ? {1'b0, c} : {c, 1'b0};
        end
    endfunction

    logic rst_meta_r;
    logic rst_sync_r;
    logic aw_full_r;
    logic w_full_r;
    logic [7:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_lane_r;
    logic [7:0] rs_r;
    logic [1:0] rate_code_r;
    logic [1:0] tape_r;
    logic [1:0] clkopt_r;
    logic [2:0] srst_cnt_r;
    logic lp_r;
    logic [6:0] init_cnt_r;
    logic ready_r;
    logic rq_r;
    logic cmd_act_r;
    logic [3:0] busy_r;

    wire rst_n = rst_sync_r;

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Bus handshakes and decode
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
    wire aw_full_nxt = (aw_full_r || aw_take) && !wr_fire;
    wire w_full_nxt = (w_full_r || w_take) && !wr_fire;
    wire bvalid_nxt = wr_fire || (s_axi_bvalid && !s_axi_bready);
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);

    wire wr_en = wr_fire && w_lane_r;
    wire wr_rs = wr_en && sel(aw_addr_r, fdc_regs_pkg::RATE_SELECT_OFS);
    wire wr_cc = wr_en && sel(aw_addr_r, fdc_regs_pkg::CONFIG_CONTROL_OFS);
    wire wr_tape = wr_en && sel(aw_addr_r, fdc_regs_pkg::TAPE_ASSIGN_OFS);
    wire wr_clk = wr_en && sel(aw_addr_r, fdc_regs_pkg::CLOCK_OPTION_OFS);
    wire wr_map = sel(aw_addr_r, fdc_regs_pkg::MAIN_STATUS_OFS)
        || sel(aw_addr_r, fdc_regs_pkg::RATE_SELECT_OFS)
        || sel(aw_addr_r, fdc_regs_pkg::CONFIG_CONTROL_OFS)
        || sel(aw_addr_r, fdc_regs_pkg::TAPE_ASSIGN_OFS)
        || sel(aw_addr_r, fdc_regs_pkg::CLOCK_OPTION_OFS)
        || sel(aw_addr_r, fdc_regs_pkg::CORE_STATE_OFS);
    wire rd_msr = sel(s_axi_araddr, fdc_regs_pkg::MAIN_STATUS_OFS);
    wire msr_rd = ar_take && rd_msr;

    // Soft reset: own self-clearing pulse or held output-control reset
    wire srst_start = wr_rs && w_data_r[fdc_regs_pkg::RS_SRST_BIT];
    wire srst_act = (srst_cnt_r != 3'h0) || evt.oc_reset;
    wire [2:0] srst_nxt = srst_start ? fdc_regs_pkg::SRST_CYC
        : (srst_cnt_r != 3'h0) ? srst_cnt_r - 3'h1 : 3'h0;

    // A main status read or any data access wakes the core; software reset too
    wire lp_set = wr_rs && w_data_r[fdc_regs_pkg::RS_LOWPWR_BIT];
    wire lp_clr = srst_act || evt.data_access || msr_rd;
    wire lp_nxt = (lp_r || lp_set) && !lp_clr;

    // Startup restarts on either reset or on wake-up
    wire restart = srst_act || (lp_r && !lp_nxt);
    wire hold = restart || lp_nxt;
    wire [6:0] init_nxt = hold ? fdc_regs_pkg::STARTUP_CYC
        : (init_cnt_r != 7'h0) ? init_cnt_r - 7'h1 : 7'h0;
    wire ready_nxt = !hold && (ready_r || init_cnt_r == 7'h1);

    // Set terms win over event clears arriving in the same cycle; a low ready_nxt clears all of them regardless
    wire rq_set = (ready_nxt && !ready_r) || evt.next_ready;
    wire rq_nxt = ready_nxt && (rq_set || (rq_r && !evt.byte_done));
    wire cmd_clr = evt.last_result || (evt.last_cmd && evt.no_result);
    wire cmd_nxt = ready_nxt && (evt.first_cmd || (cmd_act_r && !cmd_clr));
    wire [3:0] busy_set = (evt.last_cmd && evt.seek_cmd) ? onehot(evt.seek_unit) : 4'h0;
    wire [3:0] busy_clr = evt.sense_first ? onehot(evt.sense_unit) : 4'h0;
    wire [3:0] busy_nxt = {4{ready_nxt}} & (busy_set | (busy_r & ~busy_clr));

    // Live composition so a read right after a byte sees fresh state
    wire rq_bit = evt.nondma ? evt.irq : rq_r;
    wire [7:0] msr_val = ready_r
        ? {rq_bit, evt.dir_read, evt.nondma, cmd_act_r, busy_r}
        : fdc_regs_pkg::MSR_IDLE;

    wire fdc_regs_pkg::rate_t rate_now =
        rate_of(rate_code_r, clkopt_r[fdc_regs_pkg::CLKOPT_HS_BIT]);
    wire [7:0] core_val = {ready_r, lp_r, srst_act, rate_now, rate_code_r};
    wire [7:0] tape_val = {6'h00, tape_r};
    wire [7:0] clk_val = {6'h00, clkopt_r};
    wire rd_map = rd_msr || sel(s_axi_araddr, fdc_regs_pkg::RATE_SELECT_OFS)
        || sel(s_axi_araddr, fdc_regs_pkg::CONFIG_CONTROL_OFS)
        || sel(s_axi_araddr, fdc_regs_pkg::TAPE_ASSIGN_OFS)
        || sel(s_axi_araddr, fdc_regs_pkg::CLOCK_OPTION_OFS)
        || sel(s_axi_araddr, fdc_regs_pkg::CORE_STATE_OFS);
    // Write-only registers read as zero
    wire [7:0] rd_val = rd_msr ? msr_val
        : sel(s_axi_araddr, fdc_regs_pkg::TAPE_ASSIGN_OFS) ? tape_val
        : sel(s_axi_araddr, fdc_regs_pkg::CLOCK_OPTION_OFS) ? clk_val
        : sel(s_axi_araddr, fdc_regs_pkg::CORE_STATE_OFS) ? core_val : 8'h00;

    // Drive 0 stays the floppy boot drive whatever the code says
    wire [3:0] tape_mask = (tape_r == 2'h0) ? 4'h0 : onehot(tape_r) & 4'hE;
    wire [3:0] pc_units = precomp_of(rs_r[4:2], rate_now,
        clkopt_r[fdc_regs_pkg::CLKOPT_HS_BIT]);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fdc_regs_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= fdc_regs_pkg::RESP_OKAY;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
            end
            s_axi_awready <= !aw_full_nxt && !bvalid_nxt;
            s_axi_wready <= !w_full_nxt && !bvalid_nxt;
            s_axi_bvalid <= bvalid_nxt;
            if (wr_fire) begin
                s_axi_bresp <= wr_map ? fdc_regs_pkg::RESP_OKAY : fdc_regs_pkg::RESP_SLVERR;
            end
            s_axi_arready <= !rvalid_nxt;
            s_axi_rvalid <= rvalid_nxt;
            if (ar_take) begin
                s_axi_rdata <= {24'h00_0000, rd_val};
                s_axi_rresp <= rd_map ? fdc_regs_pkg::RESP_OKAY : fdc_regs_pkg::RESP_SLVERR;
            end
        end
    end

    // Settings: hardware reset only, untouched by the soft reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_r <= fdc_regs_pkg::RATE_SELECT_RST;
            rate_code_r <= fdc_regs_pkg::RATE_CODE_RST;
            tape_r <= fdc_regs_pkg::TAPE_ASSIGN_RST;
            clkopt_r <= fdc_regs_pkg::CLOCK_OPTION_RST;
        end else begin
            if (wr_rs) begin
                rs_r <= {2'b00, w_data_r[5:0]};
            end
            if (wr_rs || wr_cc) begin
                rate_code_r <= w_data_r[1:0];
            end
            if (wr_tape) begin
                tape_r <= w_data_r[1:0];
            end
            if (wr_clk) begin
                clkopt_r <= w_data_r[1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            srst_cnt_r <= 3'h0;
            lp_r <= 1'b0;
            init_cnt_r <= fdc_regs_pkg::STARTUP_CYC;
            ready_r <= 1'b0;
            rq_r <= 1'b0;
            cmd_act_r <= 1'b0;
            busy_r <= 4'h0;
        end else begin
            srst_cnt_r <= srst_nxt;
            lp_r <= lp_nxt;
            init_cnt_r <= init_nxt;
            ready_r <= ready_nxt;
            rq_r <= rq_nxt;
            cmd_act_r <= cmd_nxt;
            busy_r <= busy_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= '0;
        end else begin
            ctl.ctrl_reset <= srst_act;
            ctl.low_power <= lp_r;
            ctl.rate <= rate_now;
            ctl.rate_code <= rate_code_r;
            ctl.precomp_units <= pc_units;
            ctl.precomp_active <= (evt.cur_track >= evt.pc_track);
            ctl.tape_mask <= tape_mask;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence srst_run;
        (srst_cnt_r != 3'h0) [*4];
    endsequence
    sequence srst_done;
        (srst_cnt_r == 3'h0);
    endsequence

    srst_self_a: assert property (srst_start |=> srst_run ##1 srst_done)
        else $error("soft reset pulse length wrong");
    settings_keep_a: assert property (srst_act && !wr_rs |=> $stable(rs_r))
        else $error("soft reset disturbed rate select");
    msr_init_a: assert property (!ready_r |-> msr_val == fdc_regs_pkg::MSR_IDLE)
        else $error("status not zero during init");
    msr_ready_a: assert property ($rose(ready_r) && !evt.nondma |-> msr_val[7])
        else $error("request bit missing at ready");
    startup_bound_a: assert property (!ready_r && !lp_r && !srst_act |->
        ##[0:100] (ready_r || lp_r || srst_act))
        else $error("startup exceeds limit");
    rq_clear_a: assert property (evt.byte_done && !evt.next_ready |=>
        !rq_r)
        else $error("request bit not cleared after byte");
    rq_irq_a: assert property (ready_r && evt.nondma |-> msr_val[7] == evt.irq)
        else $error("request bit not mirroring interrupt");
    dir_nondma_a: assert property (ready_r |->
        msr_val[6:5] == {evt.dir_read, evt.nondma})
        else $error("direction or non-DMA bit wrong");
    cmd_set_a: assert property (evt.first_cmd && ready_nxt |=> msr_val[4])
        else $error("command bit not set");
    busy_set_a: assert property (evt.last_cmd && evt.seek_cmd && ready_nxt |=>
        busy_r[$past(evt.seek_unit)])
        else $error("seek busy not set");
    lp_exit_a: assert property (lp_r && (msr_rd || evt.data_access) |=> !lp_r)
        else $error("low power not ended by access");
    rate_last_a: assert property (wr_rs || wr_cc |=>
        rate_code_r == $past(w_data_r[1:0]))
        else $error("rate not taken from last write");
    tape_zero_a: assert property (##1 !ctl.tape_mask[0] &&
        (($past(tape_r) == 2'h0) == (ctl.tape_mask == 4'h0)))
        else $error("tape mapping wrong");
    precomp_zero_a: assert property (rs_r[4:2] == 3'h7 |=>
        ctl.precomp_units == 4'h0)
        else $error("zero precomp code gives delay");

endmodule

/* File: tb/fdc_host_model.sv */
/*
 * Host model: an AXI4-Lite master standing in for the processor.
 * Assumes the bench calls wr and rd one at a time, never overlapped.
 */
`timescale 1ns/100ps
module fdc_host_model (
    // Clock
    input wire logic clk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hF;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // Released payloads flip so a late sample never sees a stale match
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= (a == fdc_regs_pkg::RATE_SELECT_OFS) ? (d & 32'hFFFFFFDF) : d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask
endmodule

/* File: tb/tb.sv */
/*
 * Self-checking bench for the status and rate-select block.
 * Assumes the host model drives the bus; engine events come from here.
 */
`timescale 1ns/100ps
module tb;
    logic core_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, m;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [9:0] e;
    logic [9:0] rq[$];
    logic [1:0] bq[$];
    int err_count, cmp_count;
    fdc_regs_pkg::engine_evt_t evt, lv;
    fdc_regs_pkg::ctl_out_t ctl;
    fdc_regs_pkg::rate_t rt[4];

    fdc_status_rate u_dut (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .evt(evt), .ctl(ctl));
    fdc_host_model u_host (.clk(core_clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic fdc_regs_pkg::engine_evt_t pk(input int k, input logic [1:0] u);
        fdc_regs_pkg::engine_evt_t p;
        p = '0;
        p.seek_unit = u;
        p.sense_unit = u;
        p.first_cmd = (k == 0);
        p.last_result = (k == 1);
        p.byte_done = (k == 2);
        p.next_ready = (k == 3);
        p.data_access = (k == 4);
        p.sense_first = (k == 5);
        p.last_cmd = (k == 6);
        p.no_result = (k == 6);
        p.seek_cmd = (k == 6);
        return p;
    endfunction

    task automatic chk(input logic ok, input string s);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, s);
        end
    endtask

    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Levels in lv ride along with every pulse
    task automatic pulse(input fdc_regs_pkg::engine_evt_t p);
        @(posedge core_clk);
        evt <= p | lv;
        @(posedge core_clk);
        evt <= lv;
        @(posedge core_clk);
    endtask

    task automatic rdx(input logic [7:0] a, input logic [9:0] x);
        rq.push_back(x);
        u_host.rd(a);
    endtask

    task automatic st(input logic [7:0] v);
        rdx(fdc_regs_pkg::MAIN_STATUS_OFS, {2'h0, v});
    endtask

    task automatic wrx(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = 2'h0);
        seed = xs(seed);
        bq.push_back(r);
        u_host.wr(a, {seed[31:8], v});
    endtask

    task automatic wrs(input logic [7:0] v);
        wrx(fdc_regs_pkg::RATE_SELECT_OFS, v);
        repeat (2) @(posedge core_clk);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            e = rq.pop_front();
            chk({rresp, rdata} === {e[9:8], 24'h0, e[7:0]}, "read value");
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            chk(bresp === bq.pop_front(), "write response");
        end
    end

    initial begin
        wt(20000);
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        rt = '{fdc_regs_pkg::RATE_500K, fdc_regs_pkg::RATE_300K, fdc_regs_pkg::RATE_250K,
            fdc_regs_pkg::RATE_1M};
        seed = 32'h10;
        rstn = 1'b0;
        lv = '0;
        evt = '0;
        wt(20);
        rstn <= 1'b1;
        st(8'h00);
        rdx(fdc_regs_pkg::RATE_SELECT_OFS, 10'h000);
        chk(ctl.rate_code === 2'h2 && ctl.precomp_units === 4'h6, "reset rate");
        wt(95);
        st(8'h80);
        $display("test startup done");
        pulse(pk(0, 2'h0));
        st(8'h90);
        lv.dir_read = 1'b1;
        pulse(pk(7, 2'h0));
        st(8'hD0);
        pulse(pk(2, 2'h0));
        st(8'h50);
        pulse(pk(3, 2'h0));
        st(8'hD0);
        lv.nondma = 1'b1;
        pulse(pk(7, 2'h0));
        st(8'h70);
        lv.irq = 1'b1;
        pulse(pk(7, 2'h0));
        st(8'hF0);
        lv = '0;
        pulse(pk(1, 2'h0));
        st(8'h80);
        m = 8'h80;
        for (int u = 0; u < 4; u++) begin
            pulse(pk(0, 2'(u)));
            pulse(pk(6, 2'(u)));
            m[u] = 1'b1;
            st(m);
        end
        for (int u = 0; u < 4; u++) begin
            pulse(pk(5, 2'(u)));
            m[u] = 1'b0;
            st(m);
        end
        $display("test status done");
        for (int h = 0; h < 2; h++) begin
            wrx(fdc_regs_pkg::CLOCK_OPTION_OFS, h ? 8'h02 : 8'h01);
            for (int c = 0; c < 4; c++) begin
                wrs(8'(c));
                chk(ctl.rate === (h ? (c == 3 ? fdc_regs_pkg::RATE_2M :
                    fdc_regs_pkg::RATE_ILLEGAL) : rt[c]), "rate decode");
                if (h == 0 || c == 3) begin
                    chk(ctl.precomp_units === (c == 3 ? 4'(2 - h) : 4'h6), "default");
                end
            end
            for (int p = 1; p < 8; p++) begin
                wrs({3'h0, 3'(p), 2'h3});
                chk(ctl.precomp_units === (p == 7 ? 4'h0 : 4'(p << (1 - h))), "step");
            end
        end
        wrx(fdc_regs_pkg::CLOCK_OPTION_OFS, 8'h01);
        wrs(8'h01);
        wrx(fdc_regs_pkg::CONFIG_CONTROL_OFS, 8'h03);
        wt(2);
        chk(ctl.rate === fdc_regs_pkg::RATE_1M && ctl.rate_code === 2'h3, "cc rate");
        wrs(8'h01);
        chk(ctl.rate === fdc_regs_pkg::RATE_300K, "rs rate");
        for (int t = 0; t < 4; t++) begin
            wrx(fdc_regs_pkg::TAPE_ASSIGN_OFS, 8'(t));
            rdx(fdc_regs_pkg::TAPE_ASSIGN_OFS, 10'(t));
            chk(ctl.tape_mask === (t == 0 ? 4'h0 : 4'(1 << t)), "tape map");
        end
        lv.pc_track = 8'h05;
        lv.cur_track = 8'h04;
        pulse(pk(7, 2'h0));
        chk(ctl.precomp_active === 1'b0, "before start track");
        lv.cur_track = 8'h05;
        pulse(pk(7, 2'h0));
        chk(ctl.precomp_active === 1'b1, "from start track");
        lv = '0;
        pulse(pk(7, 2'h0));
        chk(ctl.precomp_active === 1'b1, "default start track");
        $display("test rate done");
        pulse(pk(0, 2'h0));
        wrs(8'h85);
        st(8'h00);
        wt(20);
        chk(ctl.ctrl_reset === 1'b0 && ctl.rate_code === 2'h1, "self clear");
        chk(ctl.tape_mask === 4'h8, "tape kept");
        lv.oc_reset = 1'b1;
        pulse(pk(7, 2'h0));
        wt(150);
        chk(ctl.ctrl_reset === 1'b1, "reset held");
        st(8'h00);
        lv = '0;
        pulse(pk(7, 2'h0));
        wt(105);
        st(8'h80);
        $display("test soft reset done");
        wrs(8'h41);
        chk(ctl.low_power === 1'b1, "low power on");
        pulse(pk(4, 2'h0));
        // The control output is registered one edge after the wake
        wt(1);
        chk(ctl.low_power === 1'b0, "data wake");
        wrs(8'h41);
        st(8'h00);
        wt(1);
        chk(ctl.low_power === 1'b0, "status wake");
        wt(105);
        wrx(fdc_regs_pkg::MAIN_STATUS_OFS, 8'hFF);
        st(8'h80);
        wrx(8'h20, 8'h00, fdc_regs_pkg::RESP_SLVERR);
        rdx(8'h20, {fdc_regs_pkg::RESP_SLVERR, 8'h00});
        $display("test power and map done");
        wt(4);
        end_sim();
    end
endmodule
